// ### design/rf_demod_ctrl.v
// RF demodulator control: registers, sample and quench dividers, output path
// Behaviour
// - The sample-rate field picks a demodulator sample tick of 1 MHz, 500 kHz, 250 kHz or 125 kHz.
// - The quench divide field divides quench edges by 4, 8, 16 or 32.
// - A one in the soft-reset bit holds the demodulator in reset, a zero lets it run.
// - The power-off bit powers the RF circuit down while one and up while zero.
// - System reset, soft reset or power-off resets the demodulator and forces the data output low.
// - The fast-attack bit selects a threshold of four times (0) or two times (1) the offset.
// - Bit 7 of the main control register always reads zero.
// - Six 8-bit tuning registers store and read back whatever software writes.
// - The debounce field filters data by 0, 1, 2, 4, 8 or 16 low-speed clock periods.
// - The pulse-reset field leaves pulse reset to the manual bit or pulses every 2, 4 or 8 s.
// - The output source bit routes demodulated data (0) or quench data (1) to the data output.
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "rf_demod_consts.vh"
module rf_demod_ctrl #(
    parameter PULSE_BASE_CYCLES = `PULSE_BASE_CYCLES,
    parameter FIFO_DEPTH = 8
) (
    input wire i_ref_clk,
    input wire i_nrst,
    input wire [3:0] i_address,
    input wire i_read,
    input wire i_write,
    input wire [31:0] i_writedata,
    output reg [31:0] o_readdata,
    output reg o_waitrequest,
    input wire i_quench,
    input wire i_ext_quench,
    input wire i_raw_data,
    output reg o_rf_data,
    output reg o_sample_tick,
    output reg o_quench_tick,
    output reg o_rf_power_off,
    output reg o_demod_reset,
    output reg o_threshold_x2,
    output reg [1:0] o_initial_reset_threshold_sel,
    output reg o_pulse_reset,
    output reg o_rf_clock_gate_off,
    output reg [7:0] o_tuning_1,
    output reg [7:0] o_tuning_2,
    output reg [7:0] o_tuning_3,
    output reg [7:0] o_tuning_4,
    output reg [7:0] o_tuning_5,
    output reg [7:0] o_tuning_7
);
    reg [7:0] main_control;
    reg [7:0] reset_output_control;
    reg [2:0] debounce_depth_sel;
    reg bus_done;
    reg [5:0] base_count;
    reg [2:0] rate_count;
    reg [4:0] quench_count;
    reg quench_prev;
    reg [31:0] pulse_count;
    reg [10:0] low_count;
    reg low_tick;
    reg sample_en;
    reg sampled_data;
    wire demod_hold;
    wire quench_src;
    wire quench_edge;
    wire debounced_rf_data;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire fifo_pop;
    wire access;
    reg [2:0] rate_limit;
    reg [4:0] quench_limit;
    reg [31:0] pulse_limit;
    wire [1:0] sample_rate_sel;
    wire [1:0] quench_divide_sel;
    wire [1:0] pulse_reset_interval_sel;
    wire manual_pulse_reset;
    wire output_source_sel;
    wire quench_source_sel;

    assign sample_rate_sel = main_control[`LSB_SAMPLE_RATE+1:`LSB_SAMPLE_RATE];
    assign quench_divide_sel = main_control[`LSB_QUENCH_DIV+1:`LSB_QUENCH_DIV];
    assign pulse_reset_interval_sel =
        reset_output_control[`LSB_PULSE_INTERVAL+1:`LSB_PULSE_INTERVAL];
    assign manual_pulse_reset = reset_output_control[`BIT_MANUAL_PULSE];
    assign output_source_sel = reset_output_control[`BIT_OUTPUT_SRC];
    assign quench_source_sel = reset_output_control[`BIT_QUENCH_SRC];
    assign demod_hold = main_control[`BIT_SOFT_RESET] | main_control[`BIT_POWER_OFF];
    assign quench_src = quench_source_sel ? i_ext_quench : i_quench;
    assign quench_edge = quench_src & ~quench_prev;
    assign access = (i_read | i_write) & ~bus_done;
    assign fifo_pop = access & i_read & (i_address == `OFS_FIFO_DATA);

    // Divider ratio selections
    always @* begin
        case (sample_rate_sel)
            2'h0: rate_limit = 3'h0;
            2'h1: rate_limit = 3'h1;
            2'h2: rate_limit = 3'h3;
            default: rate_limit = 3'h7;
        endcase
        case (quench_divide_sel)
            2'h0: quench_limit = 5'h03;
            2'h1: quench_limit = 5'h07;
            2'h2: quench_limit = 5'h0F;
            default: quench_limit = 5'h1F;
        endcase
        case (pulse_reset_interval_sel)
            2'h1: pulse_limit = PULSE_BASE_CYCLES - 1;
            2'h2: pulse_limit = 2 * PULSE_BASE_CYCLES - 1;
            default: pulse_limit = 4 * PULSE_BASE_CYCLES - 1;
        endcase
    end

    // Avalon slave: one wait cycle, then the answer
    always @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            bus_done <= 1'b0;
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h00000000;
        end else begin
            bus_done <= access;
            o_waitrequest <= ~access;
            if (access && i_read) begin
                case (i_address)
                    `OFS_MAIN_CONTROL: o_readdata <= {24'h000000, 1'b0, main_control[6:0]};
                    `OFS_TUNING_1: o_readdata <= {24'h000000, o_tuning_1};
                    `OFS_TUNING_2: o_readdata <= {24'h000000, o_tuning_2};
                    `OFS_TUNING_3: o_readdata <= {24'h000000, o_tuning_3};
                    `OFS_TUNING_4: o_readdata <= {24'h000000, o_tuning_4};
                    `OFS_TUNING_5: o_readdata <= {24'h000000, o_tuning_5};
                    `OFS_RESET_OUTPUT_CONTROL: o_readdata <= {24'h000000, reset_output_control};
                    `OFS_TUNING_7: o_readdata <= {24'h000000, o_tuning_7};
                    `OFS_DEBOUNCE_CONTROL:
                        o_readdata <= {24'h000000, debounced_rf_data, 4'h0, debounce_depth_sel};
                    `OFS_FIFO_DATA: o_readdata <= {23'h000000, fifo_out_valid, fifo_out_data};
                    default: o_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Register writes
    always @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            main_control <= `RST_MAIN_CONTROL;
            reset_output_control <= `RST_RESET_OUTPUT_CONTROL;
            debounce_depth_sel <= `RST_DEBOUNCE_CONTROL;
            o_tuning_1 <= `RST_TUNING;
            o_tuning_2 <= `RST_TUNING;
            o_tuning_3 <= `RST_TUNING;
            o_tuning_4 <= `RST_TUNING;
            o_tuning_5 <= `RST_TUNING;
            o_tuning_7 <= `RST_TUNING;
        end else if (access && i_write) begin
            case (i_address)
                `OFS_MAIN_CONTROL: main_control <= {1'b0, i_writedata[6:0]};
                `OFS_TUNING_1: o_tuning_1 <= i_writedata[7:0];
                `OFS_TUNING_2: o_tuning_2 <= i_writedata[7:0];
                `OFS_TUNING_3: o_tuning_3 <= i_writedata[7:0];
                `OFS_TUNING_4: o_tuning_4 <= i_writedata[7:0];
                `OFS_TUNING_5: o_tuning_5 <= i_writedata[7:0];
                `OFS_RESET_OUTPUT_CONTROL: reset_output_control <= i_writedata[7:0];
                `OFS_TUNING_7: o_tuning_7 <= i_writedata[7:0];
                `OFS_DEBOUNCE_CONTROL: debounce_depth_sel <= i_writedata[2:0];
                default: ;
            endcase
        end
    end

    // Control outputs from the stored fields
    always @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rf_power_off <= 1'b1;
            o_demod_reset <= 1'b1;
            o_threshold_x2 <= 1'b0;
            o_initial_reset_threshold_sel <= 2'h1;
            o_rf_clock_gate_off <= 1'b0;
        end else begin
            o_rf_power_off <= main_control[`BIT_POWER_OFF];
            o_demod_reset <= demod_hold;
            o_threshold_x2 <= main_control[`BIT_FAST_ATTACK];
            o_initial_reset_threshold_sel <=
                reset_output_control[`LSB_INIT_THRESH+1:`LSB_INIT_THRESH];
            o_rf_clock_gate_off <= reset_output_control[`BIT_CLOCK_GATE_OFF];
        end
    end

    // Sample tick divider and quench decimator
    always @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            base_count <= 6'h00;
            rate_count <= 3'h0;
            sample_en <= 1'b0;
            o_sample_tick <= 1'b0;
            quench_count <= 5'h00;
            quench_prev <= 1'b0;
            o_quench_tick <= 1'b0;
        end else if (demod_hold) begin
            base_count <= 6'h00;
            rate_count <= 3'h0;
            sample_en <= 1'b0;
            o_sample_tick <= 1'b0;
            quench_count <= 5'h00;
            quench_prev <= quench_src;
            o_quench_tick <= 1'b0;
        end else begin
            quench_prev <= quench_src;
            sample_en <= 1'b0;
            o_quench_tick <= 1'b0;
            if (base_count == `SAMPLE_BASE_DIV - 1) begin
                base_count <= 6'h00;
                if (rate_count >= rate_limit) begin
                    rate_count <= 3'h0;
                    sample_en <= 1'b1;
                end else begin
                    rate_count <= rate_count + 3'h1;
                end
            end else begin
                base_count <= base_count + 6'h01;
            end
            o_sample_tick <= sample_en;
            if (quench_edge) begin
                if (quench_count >= quench_limit) begin
                    quench_count <= 5'h00;
                    o_quench_tick <= 1'b1;
                end else begin
                    quench_count <= quench_count + 5'h01;
                end
            end
        end
    end

    // Low-speed tick and pulse reset timer
    always @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            low_count <= 11'h000;
            low_tick <= 1'b0;
            pulse_count <= 32'h00000000;
            o_pulse_reset <= 1'b0;
        end else begin
            low_tick <= 1'b0;
            if (low_count == `LOW_SPEED_DIV - 1) begin
                low_count <= 11'h000;
                low_tick <= 1'b1;
            end else begin
                low_count <= low_count + 11'h001;
            end
            if (pulse_reset_interval_sel == 2'h0 || demod_hold) begin
                pulse_count <= 32'h00000000;
                o_pulse_reset <= manual_pulse_reset & ~demod_hold;
            end else if (pulse_count >= pulse_limit) begin
                pulse_count <= 32'h00000000;
                o_pulse_reset <= 1'b1;
            end else begin
                pulse_count <= pulse_count + 32'h00000001;
                o_pulse_reset <= 1'b0;
            end
        end
    end

    // Sampled data and output path
    always @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sampled_data <= 1'b0;
            o_rf_data <= 1'b0;
        end else if (demod_hold) begin
            sampled_data <= 1'b0;
            o_rf_data <= 1'b0;
        end else begin
            if (sample_en) begin
                sampled_data <= i_raw_data;
            end
            o_rf_data <= output_source_sel ? quench_src : debounced_rf_data;
        end
    end

    rf_debounce u_debounce (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_clear(demod_hold),
        .i_tick(low_tick),
        .i_depth_sel(debounce_depth_sel),
        .i_data(sampled_data),
        .o_data(debounced_rf_data)
    );

    // Captures each sample of debounced data while not full, dropping samples once full; software drains it
    rf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_clear(demod_hold),
        .i_in_valid(sample_en),
        .o_in_ready(fifo_in_ready),
        .i_in_data({7'h00, debounced_rf_data}),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_out_data)
    );
endmodule
`default_nettype wire

// ### design/rf_demod_consts.vh
// Constants for the RF demodulator control block
`ifndef RF_DEMOD_CONSTS_VH
`define RF_DEMOD_CONSTS_VH
`define OFS_MAIN_CONTROL 4'h0
`define OFS_TUNING_1 4'h1
`define OFS_TUNING_2 4'h2
`define OFS_TUNING_3 4'h3
`define OFS_TUNING_4 4'h4
`define OFS_TUNING_5 4'h5
`define OFS_RESET_OUTPUT_CONTROL 4'h6
`define OFS_TUNING_7 4'h7
`define OFS_DEBOUNCE_CONTROL 4'h8
`define OFS_FIFO_DATA 4'h9
`define RST_MAIN_CONTROL 8'h2B
`define RST_RESET_OUTPUT_CONTROL 8'h88
`define RST_DEBOUNCE_CONTROL 3'h1
`define RST_TUNING 8'h00
`define BIT_POWER_OFF 0
`define LSB_QUENCH_DIV 1
`define BIT_SOFT_RESET 3
`define LSB_SAMPLE_RATE 4
`define BIT_FAST_ATTACK 6
`define BIT_CLOCK_GATE_OFF 0
`define BIT_OUTPUT_SRC 1
`define BIT_QUENCH_SRC 2
`define LSB_INIT_THRESH 3
`define BIT_MANUAL_PULSE 5
`define LSB_PULSE_INTERVAL 6
`define BIT_DEBOUNCED_DATA 7
`define CLK_HZ 50000000
`define SAMPLE_BASE_HZ 1000000
`define SAMPLE_BASE_DIV (`CLK_HZ / `SAMPLE_BASE_HZ)
`define LOW_SPEED_HZ 32000
`define LOW_SPEED_DIV (`CLK_HZ / `LOW_SPEED_HZ)
`define PULSE_BASE_S 2
`define PULSE_BASE_CYCLES (`CLK_HZ * `PULSE_BASE_S)
`endif

// ### design/rf_fifo.v
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module rf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire i_ref_clk,
    input wire i_nrst,
    input wire i_clear,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output reg [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;
    assign o_in_ready = (count != DEPTH[AW:0]);
    assign o_out_valid = (count != {(AW+1){1'b0}});
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    always @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end
    always @* begin
        o_out_data = mem[rd_ptr];
    end
    always @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else if (i_clear) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### design/rf_debounce.v
// Debounce filter for demodulated data, stepped by a low-speed enable
`timescale 1ns/1ns
`default_nettype none
module rf_debounce (
    input wire i_ref_clk,
    input wire i_nrst,
    input wire i_clear,
    input wire i_tick,
    input wire [2:0] i_depth_sel,
    input wire i_data,
    output reg o_data
);
    reg [4:0] stable_count;
    reg [4:0] need;
    always @* begin
        case (i_depth_sel)
            3'h1: need = 5'h01;
            3'h2: need = 5'h02;
            3'h3: need = 5'h04;
            3'h4: need = 5'h08;
            3'h5: need = 5'h10;
            default: need = 5'h00;
        endcase
    end
    always @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_data <= 1'b0;
            stable_count <= 5'h00;
        end else if (i_clear) begin
            o_data <= 1'b0;
            stable_count <= 5'h00;
        end else if (need == 5'h00) begin
            o_data <= i_data;
            stable_count <= 5'h00;
        end else if (i_data == o_data) begin
            stable_count <= 5'h00;
        end else if (i_tick) begin
            if (stable_count + 5'h01 >= need) begin
                o_data <= i_data;
                stable_count <= 5'h00;
            end else begin
                stable_count <= stable_count + 5'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/rf_demod_ctrl_assertions.sv
// Concurrent checks on the RF demodulator control ports
`timescale 1ns/1ns
`default_nettype none
`include "rf_demod_consts.vh"
module rf_demod_ctrl_assertions (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    input wire logic o_rf_data,
    input wire logic o_sample_tick,
    input wire logic o_rf_power_off,
    input wire logic o_demod_reset,
    input wire logic o_threshold_x2,
    input wire logic [7:0] o_tuning_1
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    // Completed write and read cycles
    sequence s_wr(a);
        i_write && !o_waitrequest && i_address == a;
    endsequence
    sequence s_rd(a);
        i_read && !o_waitrequest && i_address == a;
    endsequence
    a_answer_next: assert property (
        (i_read || i_write) && o_waitrequest && $past(o_waitrequest) |=> !o_waitrequest)
        else $error("Request not answered in the next cycle");
    a_answer_single: assert property (
        !o_waitrequest |=> o_waitrequest) else $error("Answer longer than one cycle");
    a_main_bit7: assert property (
        s_rd(`OFS_MAIN_CONTROL) |-> !o_readdata[7]) else $error("Main bit 7 read as one");
    a_unmapped_zero: assert property (
        i_read && !o_waitrequest && i_address > 4'h9 |-> o_readdata == 32'h0)
        else $error("Unmapped read not zero");
    a_power_write: assert property (
        s_wr(`OFS_MAIN_CONTROL) |-> ##2 o_rf_power_off == $past(i_writedata[0], 2))
        else $error("Power-off output does not follow write");
    a_soft_reset: assert property (
        s_wr(`OFS_MAIN_CONTROL) |-> ##2
        o_demod_reset == ($past(i_writedata[0], 2) | $past(i_writedata[3], 2)))
        else $error("Demodulator reset does not follow write");
    a_threshold_write: assert property (
        s_wr(`OFS_MAIN_CONTROL) |-> ##2 o_threshold_x2 == $past(i_writedata[6], 2))
        else $error("Threshold select does not follow write");
    a_tuning_write: assert property (
        s_wr(`OFS_TUNING_1) |-> ##2 o_tuning_1 == $past(i_writedata[7:0], 2))
        else $error("Tuning register does not follow write");
    a_data_forced_low: assert property (
        o_demod_reset [*3] |-> !o_rf_data) else $error("Data output high in reset");
    a_tick_single: assert property (
        o_sample_tick |=> !o_sample_tick [*8]) else $error("Sample ticks too close");
endmodule
bind rf_demod_ctrl rf_demod_ctrl_assertions rf_demod_ctrl_assertions_inst (.*);
`default_nettype wire

// ### testbench/rf_front_end_model.sv
// Front end model: quench oscillators and raw demodulator data
`timescale 1ns/1ns
`default_nettype none
module rf_front_end_model #(
    parameter int HALF_INT = 3,
    parameter int HALF_EXT = 5
) (
    input wire logic i_ref_clk,
    input wire logic i_power_off,
    input wire logic i_level,
    output logic o_quench = 1'b0,
    output logic o_ext_quench = 1'b0,
    output logic o_raw_data = 1'b0
);
    int cnt = 0;
    always @(posedge i_ref_clk) begin
        cnt <= cnt + 1;
        o_quench <= !i_power_off && ((cnt / HALF_INT) % 2 == 1);
        o_ext_quench <= ((cnt / HALF_EXT) % 2 == 1);
        o_raw_data <= !i_power_off && i_level;
    end
endmodule
`default_nettype wire

// ### testbench/rf_demod_ctrl_bench.sv
// Self-checking bench for the RF demodulator control block
`timescale 1ns/1ns
`default_nettype none
`include "rf_demod_consts.vh"
module rf_demod_ctrl_bench;
    localparam int PULSE = 200;
    typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] r;} row_t;
    row_t rows [9] = '{'{4'h0, 8'hFF, 8'h7F}, '{4'h1, 8'hA5, 8'hA5}, '{4'h2, 8'h5A, 8'h5A},
        '{4'h3, 8'h3C, 8'h3C}, '{4'h4, 8'hC3, 8'hC3}, '{4'h5, 8'h96, 8'h96},
        '{4'h7, 8'h69, 8'h69}, '{4'h6, 8'h7E, 8'h7E}, '{4'hC, 8'h55, 8'h00}};
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [3:0] i_address = 4'h0;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [31:0] o_readdata;
    logic [31:0] rd;
    logic o_waitrequest, i_quench, i_ext_quench, i_raw_data, o_rf_data, o_sample_tick;
    logic o_quench_tick, o_rf_power_off, o_demod_reset, o_threshold_x2, o_pulse_reset;
    logic level = 1'b0;
    int mismatches = 0;
    int checked = 0;
    int n;
    rf_front_end_model rf_front_end_model_inst (.i_ref_clk(i_ref_clk),
        .i_power_off(o_rf_power_off), .i_level(level), .o_quench(i_quench),
        .o_ext_quench(i_ext_quench), .o_raw_data(i_raw_data));
    rf_demod_ctrl #(.PULSE_BASE_CYCLES(PULSE)) rf_demod_ctrl_inst (.i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst), .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_quench(i_quench), .i_ext_quench(i_ext_quench), .i_raw_data(i_raw_data),
        .o_rf_data(o_rf_data), .o_sample_tick(o_sample_tick), .o_quench_tick(o_quench_tick),
        .o_rf_power_off(o_rf_power_off), .o_demod_reset(o_demod_reset),
        .o_threshold_x2(o_threshold_x2), .o_initial_reset_threshold_sel(),
        .o_pulse_reset(o_pulse_reset), .o_rf_clock_gate_off(), .o_tuning_1(), .o_tuning_2(),
        .o_tuning_3(), .o_tuning_4(), .o_tuning_5(), .o_tuning_7());
    initial begin
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic hang;
        mismatches++;
        $display("BAD t=%0t wait ran out got=%h exp=%h", $time, 1'b0, 1'b1);
        end_sim;
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return o_sample_tick;
            1: return o_quench_tick;
            2: return o_pulse_reset;
            3: return o_rf_data;
            default: return o_waitrequest;
        endcase
    endfunction
    // Waits at falling edges until the chosen output shows v; n counts the cycles
    task automatic wait_sig(input int k, input logic v, input int lim);
        n = 0;
        while (sig(k) !== v) begin
            if (n == lim) hang;
            @(negedge i_ref_clk);
            n++;
        end
    endtask
    // Holds the request until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int w;
        @(posedge i_ref_clk);
        i_address <= a;
        i_writedata <= {24'h0, d};
        i_write <= wr;
        i_read <= !wr;
        w = 0;
        do begin
            @(posedge i_ref_clk);
            w++;
            if (w > 50) hang;
        end while (o_waitrequest !== 1'b0);
        rd = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask
    task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check_word(rd, {24'h0, exp});
    endtask
    // Spacing of pulses on output k, measured after two settling pulses
    task automatic period(input int k, input int exp);
        repeat (2) begin
            wait_sig(k, 1'b1, 4000);
            @(negedge i_ref_clk);
        end
        wait_sig(k, 1'b1, 4000);
        check_word(32'(n + 1), 32'(exp));
    endtask
    task automatic settle;
        repeat (4) @(negedge i_ref_clk);
    endtask
    initial begin
        repeat (8) @(posedge i_ref_clk);
        check_word(32'({o_rf_power_off, o_demod_reset, o_rf_data, o_waitrequest}), 32'hD);
        i_nrst <= 1'b1;
        rd_check(4'h0, `RST_MAIN_CONTROL);
        rd_check(4'h6, `RST_RESET_OUTPUT_CONTROL);
        rd_check(4'h8, {5'h00, `RST_DEBOUNCE_CONTROL});
        rd_check(4'h7, `RST_TUNING);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].w);
            rd_check(rows[i].a, rows[i].r);
        end
        bus(1'b1, 4'h8, 8'h7E);
        rd_check(4'h8, 8'h06);
        bus(1'b1, 4'h6, 8'h08);
        bus(1'b1, 4'h8, 8'h00);
        bus(1'b1, 4'h0, 8'h48);
        level <= 1'b1;
        repeat (50) @(negedge i_ref_clk);
        check_word(32'({o_rf_power_off, o_demod_reset, o_threshold_x2, o_rf_data}), 32'h6);
        bus(1'b1, 4'h0, 8'h00);
        wait_sig(3, 1'b1, 200);
        rd_check(4'h8, 8'h80);
        bus(1'b1, 4'h0, 8'h01);
        settle;
        check_word(32'({o_rf_power_off, o_demod_reset, o_rf_data}), 32'h6);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, 4'h0, {2'b00, 2'(c), 1'b0, 2'(c), 1'b0});
            period(0, 50 << c);
            period(1, 6 * (4 << c));
        end
        bus(1'b1, 4'h6, 8'h0C);
        period(1, 10 * 32);
        bus(1'b1, 4'h6, 8'h0A);
        wait_sig(3, 1'b0, 50);
        wait_sig(3, 1'b1, 50);
        wait_sig(3, 1'b0, 50);
        check_word(32'(n), 32'd3);
        bus(1'b1, 4'h0, 8'h00);
        bus(1'b1, 4'h6, 8'h08);
        level <= 1'b0;
        wait_sig(3, 1'b0, 100);
        bus(1'b1, 4'h8, 8'h02);
        level <= 1'b1;
        wait_sig(3, 1'b1, 6000);
        check_word(32'(n > 1500 && n < 3200), 32'h1);
        bus(1'b1, 4'h6, 8'h28);
        settle;
        check_word(32'(o_pulse_reset), 32'h1);
        for (int k = 1; k < 4; k++) begin
            bus(1'b1, 4'h6, {2'(k), 6'h08});
            period(2, PULSE << (k - 1));
        end
        bus(1'b1, 4'h8, 8'h00);
        bus(1'b1, 4'h0, 8'h31);
        bus(1'b1, 4'h0, 8'h30);
        repeat (4000) @(posedge i_ref_clk);
        // The first sample after the hold sees the debounced output still cleared
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 4'h9, 8'h00);
            check_word(rd & 32'h101, (i == 0) ? 32'h100 : 32'h101);
        end
        bus(1'b0, 4'h9, 8'h00);
        check_word(32'(rd[8]), 32'h0);
        i_nrst <= 1'b0;
        settle;
        check_word(32'({o_rf_power_off, o_demod_reset, o_rf_data}), 32'h6);
        end_sim;
    end
endmodule
`default_nettype wire
